// ---- core/glss_regs.vh ----
`ifndef GLSS_REGS_VH
`define GLSS_REGS_VH
// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define GLSS_ADR_CTRL      4'h0
`define GLSS_ADR_DUM_TRIP  4'h1
`define GLSS_ADR_DUM_RET   4'h2
`define GLSS_ADR_SHD_TRIP  4'h3
`define GLSS_ADR_SHD_RET   4'h4
`define GLSS_ADR_DUM_TDLY  4'h5
`define GLSS_ADR_DUM_RDLY  4'h6
`define GLSS_ADR_SHD_TDLY  4'h7
`define GLSS_ADR_SHD_RDLY  4'h8
`define GLSS_ADR_STATUS    4'h9
`define GLSS_ADR_KW        4'hA
// ---------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------
`define GLSS_CTL_DUM_EN    0
`define GLSS_CTL_SHD_EN    1
`define GLSS_CTL_DUM_NLO   4
`define GLSS_CTL_DUM_NHI   6
`define GLSS_CTL_SHD_NLO   8
`define GLSS_CTL_SHD_NHI   10
`define GLSS_CTL_SST_LO    12
`define GLSS_CTL_SST_HI    14
`define GLSS_CTRL_RST      32'h0000_0000
`define GLSS_DLY_RST       32'h0000_0100
`define GLSS_LVL_RST       16'h0000
`endif

// ---- core/glss_step_timer.v ----
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Qualify timer: counts while cond holds, fires at limit
// ---------------------------------------------------------------
module glss_step_timer #(
  parameter W = 32
) (
  input  wire         clk,
  input  wire         srst,
  input  wire         run,
  input  wire [W-1:0] limit,
  output reg          fire
);
  reg [W-1:0] cnt_r;

  // Count while run; drop to zero when condition lapses
  always @(posedge clk) begin
    if (srst || !run) begin
      cnt_r <= {W{1'b0}};
      fire  <= 1'b0;
    end else if (cnt_r >= limit) begin
      cnt_r <= {W{1'b0}};
      fire  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
      fire  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- core/glss_stage_bank.v ----
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Thermometer stage bank: add next / remove highest
// ---------------------------------------------------------------
module glss_stage_bank #(
  parameter N = 5
) (
  input  wire         clk,
  input  wire         srst,
  input  wire         clr,
  input  wire         load,
  input  wire [2:0]   load_cnt,
  input  wire         up,
  input  wire         dn,
  input  wire [2:0]   max_cnt,
  output reg  [2:0]   cnt_r,
  output wire [N-1:0] outs
);
  wire [2:0] lim = (max_cnt > N[2:0]) ? N[2:0] : max_cnt;

  // Active step count
  always @(posedge clk) begin
    if (srst || clr)
      cnt_r <= 3'h0;
    else if (load)
      cnt_r <= (load_cnt > lim) ? lim : load_cnt;
    else if (up && cnt_r < lim)
      cnt_r <= cnt_r + 3'h1;
    else if (dn && cnt_r != 3'h0)
      cnt_r <= cnt_r - 3'h1;
  end

  // Output i is on while count exceeds i
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_out
      assign outs[i] = (cnt_r > i);
    end
  endgenerate
endmodule
`default_nettype wire

// ---- core/glss_top.v ----
// Added by the designer: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "glss_regs.vh"

// Notes on behaviour
// - Up to five dummy-load steps, count set by software, one output each.
// - Dummy outputs are off at start; monitoring starts only when on load.
// - Load below dummy trip for the trip delay energises the next dummy step.
// - The trip qualification repeats after each step until all are on.
// - Load above dummy return for the return delay drops the highest dummy step.
// - A stopping sequence clears every dummy and shed output with switch open.
// - Up to five shedding steps, count set by software, one output each.
// - Pre-load seen before on load energises the start count of shed outputs by the time the switch closes.
// - Load above shed trip for the trip delay energises the next shed step.
// - Each further full trip delay above the level adds the next shed step.
// - Load below shed return for the return delay drops the highest shed step.
module glss_top #(
  parameter N_DUM = 5,
  parameter N_SHD = 5,
  parameter KW_W  = 16
) (
  input  wire             clk,
  input  wire             srst,
  input  wire [31:0]      wb_adr_i,
  input  wire [31:0]      wb_dat_i,
  output reg  [31:0]      wb_dat_o,
  input  wire [3:0]       wb_sel_i,
  input  wire             wb_we_i,
  input  wire             wb_cyc_i,
  input  wire             wb_stb_i,
  output reg              wb_ack_o,
  input  wire [KW_W-1:0]  kw_meas,
  input  wire             on_load,
  input  wire             pre_load,
  input  wire             stopping,
  output reg              load_sw_open,
  output reg  [N_DUM-1:0] dummy_out,
  output reg  [N_SHD-1:0] shed_out
);
  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  reg [2:0] s1_r;
  reg [2:0] s2_r;
  reg [KW_W-1:0] kw1_r;
  reg [KW_W-1:0] kw2_r;
  always @(posedge clk) begin
    if (srst) begin
      s1_r  <= 3'h0;
      s2_r  <= 3'h0;
      kw1_r <= {KW_W{1'b0}};
      kw2_r <= {KW_W{1'b0}};
    end else begin
      s1_r  <= {stopping, pre_load, on_load};
      s2_r  <= s1_r;
      kw1_r <= kw_meas;
      kw2_r <= kw1_r;
    end
  end
  wire onl  = s2_r[0];
  wire prel = s2_r[1];
  wire stp  = s2_r[2];

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg [31:0]     ctrl_r;
  reg [KW_W-1:0] dum_trip_r;
  reg [KW_W-1:0] dum_ret_r;
  reg [KW_W-1:0] shd_trip_r;
  reg [KW_W-1:0] shd_ret_r;
  reg [31:0]     dum_tdly_r;
  reg [31:0]     dum_rdly_r;
  reg [31:0]     shd_tdly_r;
  reg [31:0]     shd_rdly_r;
  wire [3:0]     ridx = wb_adr_i[5:2];
  wire           wr   = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  wire [2:0]     dum_cnt;
  wire [2:0]     shd_cnt;

  // Byte-lane write merge
  function [31:0] mrg;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer k;
    begin
      mrg = old;
      for (k = 0; k < 4; k = k + 1)
        if (sel[k])
          mrg[k*8 +: 8] = nw[k*8 +: 8];
    end
  endfunction

  // ---------------------------------------------------------------
  // Level registers widened to the bus word
  // ---------------------------------------------------------------
  localparam PADW = 32 - KW_W;
  wire [31:0] dum_trip_w = {{PADW{1'b0}}, dum_trip_r};
  wire [31:0] dum_ret_w  = {{PADW{1'b0}}, dum_ret_r};
  wire [31:0] shd_trip_w = {{PADW{1'b0}}, shd_trip_r};
  wire [31:0] shd_ret_w  = {{PADW{1'b0}}, shd_ret_r};
  wire [31:0] kw_w       = {{PADW{1'b0}}, kw2_r};

  // Merged write words; only the low level bits are kept
  wire [31:0] dum_trip_m = mrg(dum_trip_w, wb_dat_i, wb_sel_i);
  wire [31:0] dum_ret_m  = mrg(dum_ret_w, wb_dat_i, wb_sel_i);
  wire [31:0] shd_trip_m = mrg(shd_trip_w, wb_dat_i, wb_sel_i);
  wire [31:0] shd_ret_m  = mrg(shd_ret_w, wb_dat_i, wb_sel_i);

  // Register writes
  always @(posedge clk) begin
    if (srst) begin
      ctrl_r     <= `GLSS_CTRL_RST;
      dum_trip_r <= `GLSS_LVL_RST;
      dum_ret_r  <= `GLSS_LVL_RST;
      shd_trip_r <= `GLSS_LVL_RST;
      shd_ret_r  <= `GLSS_LVL_RST;
      dum_tdly_r <= `GLSS_DLY_RST;
      dum_rdly_r <= `GLSS_DLY_RST;
      shd_tdly_r <= `GLSS_DLY_RST;
      shd_rdly_r <= `GLSS_DLY_RST;
    end else if (wr) begin
      case (ridx)
        `GLSS_ADR_CTRL:     ctrl_r     <= mrg(ctrl_r, wb_dat_i, wb_sel_i);
        `GLSS_ADR_DUM_TRIP: dum_trip_r <= dum_trip_m[KW_W-1:0];
        `GLSS_ADR_DUM_RET:  dum_ret_r  <= dum_ret_m[KW_W-1:0];
        `GLSS_ADR_SHD_TRIP: shd_trip_r <= shd_trip_m[KW_W-1:0];
        `GLSS_ADR_SHD_RET:  shd_ret_r  <= shd_ret_m[KW_W-1:0];
        `GLSS_ADR_DUM_TDLY: dum_tdly_r <= mrg(dum_tdly_r, wb_dat_i, wb_sel_i);
        `GLSS_ADR_DUM_RDLY: dum_rdly_r <= mrg(dum_rdly_r, wb_dat_i, wb_sel_i);
        `GLSS_ADR_SHD_TDLY: shd_tdly_r <= mrg(shd_tdly_r, wb_dat_i, wb_sel_i);
        `GLSS_ADR_SHD_RDLY: shd_rdly_r <= mrg(shd_rdly_r, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // Read mux and one-cycle ack
  always @(posedge clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      case (ridx)
        `GLSS_ADR_CTRL:     wb_dat_o <= ctrl_r;
        `GLSS_ADR_DUM_TRIP: wb_dat_o <= dum_trip_w;
        `GLSS_ADR_DUM_RET:  wb_dat_o <= dum_ret_w;
        `GLSS_ADR_SHD_TRIP: wb_dat_o <= shd_trip_w;
        `GLSS_ADR_SHD_RET:  wb_dat_o <= shd_ret_w;
        `GLSS_ADR_DUM_TDLY: wb_dat_o <= dum_tdly_r;
        `GLSS_ADR_DUM_RDLY: wb_dat_o <= dum_rdly_r;
        `GLSS_ADR_SHD_TDLY: wb_dat_o <= shd_tdly_r;
        `GLSS_ADR_SHD_RDLY: wb_dat_o <= shd_rdly_r;
        `GLSS_ADR_STATUS:   wb_dat_o <= {21'h00_0000, stp, prel, onl,
                                         1'b0, shd_cnt, 1'b0, dum_cnt};
        `GLSS_ADR_KW:       wb_dat_o <= kw_w;
        default:            wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Configuration fields
  // ---------------------------------------------------------------
  wire       dum_en  = ctrl_r[`GLSS_CTL_DUM_EN];
  wire       shd_en  = ctrl_r[`GLSS_CTL_SHD_EN];
  wire [2:0] dum_n   = ctrl_r[`GLSS_CTL_DUM_NHI:`GLSS_CTL_DUM_NLO];
  wire [2:0] shd_n   = ctrl_r[`GLSS_CTL_SHD_NHI:`GLSS_CTL_SHD_NLO];
  wire [2:0] shd_sst = ctrl_r[`GLSS_CTL_SST_HI:`GLSS_CTL_SST_LO];

  // ---------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_PRE  = 3'b010;
  localparam ST_ON   = 3'b100;
  reg [2:0] st_r;
  reg [2:0] st_nxt;

  // State transitions
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: if (stp) st_nxt = ST_IDLE;
               else if (onl) st_nxt = ST_ON;
               else if (prel) st_nxt = ST_PRE;
      ST_PRE:  if (stp) st_nxt = ST_IDLE;
               else if (onl) st_nxt = ST_ON;
      ST_ON:   if (stp || !onl) st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (srst)
      st_r <= ST_IDLE;
    else
      st_r <= st_nxt;
  end

  wire mon     = (st_r == ST_ON) && !stp;
  wire clr_all = stp || (st_nxt == ST_IDLE);
  wire pre_ent = (st_r == ST_IDLE) && (st_nxt == ST_PRE);

  // Switch stays open until on load, so start sheds settle first
  wire sw_open_nxt = (st_nxt != ST_ON);

  // ---------------------------------------------------------------
  // Threshold comparisons and timers
  // ---------------------------------------------------------------
  wire d_low  = mon && dum_en && (kw2_r < dum_trip_r);
  wire d_high = mon && dum_en && (kw2_r > dum_ret_r);
  wire s_high = mon && shd_en && (kw2_r > shd_trip_r);
  wire s_low  = mon && shd_en && (kw2_r < shd_ret_r);
  wire d_up;
  wire d_dn;
  wire s_up;
  wire s_dn;

  // Dummy trip delay; drops its count when the condition lapses
  glss_step_timer u_dtrip (
    .clk   (clk),
    .srst  (srst),
    .run   (d_low),
    .limit (dum_tdly_r),
    .fire  (d_up)
  );

  // Dummy return delay
  glss_step_timer u_dret (
    .clk   (clk),
    .srst  (srst),
    .run   (d_high),
    .limit (dum_rdly_r),
    .fire  (d_dn)
  );

  // Shed trip delay; restarts after each step
  glss_step_timer u_strip (
    .clk   (clk),
    .srst  (srst),
    .run   (s_high),
    .limit (shd_tdly_r),
    .fire  (s_up)
  );

  // Shed return delay
  glss_step_timer u_sret (
    .clk   (clk),
    .srst  (srst),
    .run   (s_low),
    .limit (shd_rdly_r),
    .fire  (s_dn)
  );

  // ---------------------------------------------------------------
  // Step banks
  // ---------------------------------------------------------------
  wire [N_DUM-1:0] d_outs;
  wire [N_SHD-1:0] s_outs;

  // Dummy bank: no start count, steps only while monitoring
  glss_stage_bank #(
    .N(N_DUM)
  ) u_dum (
    .clk      (clk),
    .srst     (srst),
    .clr      (clr_all),
    .load     (1'b0),
    .load_cnt (3'h0),
    .up       (d_up && mon),
    .dn       (d_dn && mon),
    .max_cnt  (dum_n),
    .cnt_r    (dum_cnt),
    .outs     (d_outs)
  );

  // Shed bank: start count loaded on the way to load
  glss_stage_bank #(
    .N(N_SHD)
  ) u_shd (
    .clk      (clk),
    .srst     (srst),
    .clr      (clr_all),
    .load     (pre_ent && shd_en),
    .load_cnt (shd_sst),
    .up       (s_up && mon),
    .dn       (s_dn && mon),
    .max_cnt  (shd_n),
    .cnt_r    (shd_cnt),
    .outs     (s_outs)
  );

  // Outputs: cleared in the same cycle the switch-open rises
  always @(posedge clk) begin
    if (srst) begin
      load_sw_open <= 1'b1;
      dummy_out    <= {N_DUM{1'b0}};
      shed_out     <= {N_SHD{1'b0}};
    end else begin
      load_sw_open <= sw_open_nxt;
      dummy_out    <= clr_all ? {N_DUM{1'b0}} : d_outs;
      shed_out     <= clr_all ? {N_SHD{1'b0}} : s_outs;
    end
  end
endmodule
`default_nettype wire

// ---- test/glss_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Port checker
// ---------------------------------------------------------------
module glss_asserts #(
  parameter N_DUM = 5,
  parameter N_SHD = 5
) (
  input wire logic             clk,
  input wire logic             srst,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_ack_o,
  input wire logic             on_load,
  input wire logic             stopping,
  input wire logic             load_sw_open,
  input wire logic [N_DUM-1:0] dummy_out,
  input wire logic [N_SHD-1:0] shed_out
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  // Bus answer next cycle, one cycle wide
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  // Outputs fill from the bottom
  a_dum_therm: assert property ((dummy_out & (dummy_out + 1'b1)) == 0)
    else $error("dummy gap");
  a_shd_therm: assert property ((shed_out & (shed_out + 1'b1)) == 0)
    else $error("shed gap");
  // One step at a time while on load
  a_dum_step: assert property (!$stable(dummy_out) && dummy_out != 0 |->
    dummy_out == (($past(dummy_out) << 1) | 1'b1) || dummy_out == $past(dummy_out) >> 1)
    else $error("dummy jump");
  a_shd_step: assert property (!$stable(shed_out) && shed_out != 0 &&
    !load_sw_open && !$past(load_sw_open) |->
    shed_out == (($past(shed_out) << 1) | 1'b1) || shed_out == $past(shed_out) >> 1)
    else $error("shed jump");
  // Stop clears everything with the switch
  a_stop_clear: assert property ($rose(load_sw_open) |->
    dummy_out == 0 && shed_out == 0)
    else $error("outputs left on");
  a_stop_open: assert property ($rose(stopping) |-> ##[1:4] load_sw_open)
    else $error("switch not opened");
  a_off_open: assert property ($fell(on_load) |-> ##[1:4] load_sw_open)
    else $error("switch not opened");
  a_open_nodum: assert property (load_sw_open |-> dummy_out == 0)
    else $error("dummy while off");
  c_dum_full: cover property (&dummy_out);
  c_shd_full: cover property (&shed_out);
  c_stop: cover property ($rose(stopping));
endmodule
bind glss_top glss_asserts #(.N_DUM(N_DUM), .N_SHD(N_SHD)) u_glss_asserts (
  .clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .on_load(on_load), .stopping(stopping), .load_sw_open(load_sw_open),
  .dummy_out(dummy_out), .shed_out(shed_out));
`default_nettype wire

// ---- test/glss_relay_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Relays and plant: banks add load, shed loads remove it
// ---------------------------------------------------------------
module glss_relay_model #(
  parameter STEP = 10
) (
  input  wire logic        clk,
  input  wire logic [15:0] base_kw,
  input  wire logic [4:0]  dummy_out,
  input  wire logic [4:0]  shed_out,
  output var  logic [15:0] kw_meas
);
  // Contacts follow the coils one cycle late
  always_ff @(posedge clk) begin
    kw_meas <= base_kw + 16'(STEP * $countones(dummy_out)) - 16'(STEP * $countones(shed_out));
  end
endmodule
`default_nettype wire

// ---- test/tb_glss_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_glss_top;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic        clk = 0;
  logic        srst = 1;
  logic [31:0] adr = 0;
  logic [31:0] dat = 0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic        we = 0;
  logic        cyc = 0;
  logic        ack;
  logic [15:0] base = 16'h0028;
  logic [15:0] kw;
  logic        on_ld = 0;
  logic        pre = 0;
  logic        stp = 0;
  logic        sw_open;
  logic [4:0]  dum;
  logic [4:0]  shd;
  int          fails = 0;
  int          checks_done = 0;
  int          n;
  logic [31:0] cfg [8] = '{32'h0000_0064, 32'h0000_012c, 32'h0000_0320, 32'h0000_0258,
                           32'h0000_0004, 32'h0000_0004, 32'h0000_0004, 32'h0000_0004};
  always #4 clk = ~clk;
  glss_top u_glss_top (
    .clk(clk), .srst(srst), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack),
    .kw_meas(kw), .on_load(on_ld), .pre_load(pre), .stopping(stp),
    .load_sw_open(sw_open), .dummy_out(dum), .shed_out(shd));
  glss_relay_model u_glss_relay_model (
    .clk(clk), .base_kw(base), .dummy_out(dum), .shed_out(shd), .kw_meas(kw));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Classic cycle: hold until ack, then release for one idle cycle
  task automatic wb(input logic w, input logic [3:0] idx, input logic [31:0] d);
    adr <= {26'h0, idx, 2'b00};
    dat <= d;
    we <= w;
    cyc <= 1'b1;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic settle(input logic [4:0] cur);
    n = 0;
    while (cur === 0 && n < 40) begin
      @(posedge clk);
      cur = shd;
      n++;
    end
  endtask
  task automatic stop_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    wb(0, 4'h0, 0);
    chk("ctrl", rd, 32'h0000_0000);
    wb(0, 4'h8, 0);
    chk("dly", rd, 32'h0000_0100);
    wb(1, 4'hf, 32'h1234_5678);
    wb(0, 4'hf, 0);
    chk("unmapped", rd, 32'h0000_0000);
    foreach (cfg[i]) wb(1, 4'(i + 1), cfg[i]);
    foreach (cfg[i]) begin
      wb(0, 4'(i + 1), 0);
      chk("cfg", rd, cfg[i]);
    end
    wb(1, 4'h0, 32'h0000_2553);
    $display("test registers done");
    pre <= 1'b1;
    repeat (8) @(posedge clk);
    chk("idle dum", dum, 0);
    chk("start shed", shd, 32'h0000_0003);
    chk("start open", sw_open, 1);
    on_ld <= 1'b1;
    pre <= 1'b0;
    repeat (150) @(posedge clk);
    chk("dum full", dum, 32'h0000_001f);
    chk("shed back", shd, 0);
    wb(0, 4'h9, 0);
    chk("dum cnt", rd[2:0], 5);
    base <= 16'h0140;
    repeat (150) @(posedge clk);
    chk("dum ret", dum, 0);
    $display("test dummy done");
    wb(1, 4'h5, 32'h0000_0040);
    for (int k = 0; k < 2; k++) begin
      base <= 16'h0028;
      repeat (40) @(posedge clk);
      base <= 16'h00c8;
      repeat (60) @(posedge clk);
      chk("cancel", dum, 0);
    end
    base <= 16'h0384;
    settle(shd);
    chk("shed first", shd, 32'h0000_0001);
    repeat (150) @(posedge clk);
    chk("shed full", shd, 32'h0000_001f);
    base <= 16'h01f4;
    repeat (150) @(posedge clk);
    chk("shed ret", shd, 0);
    $display("test shed done");
    wb(1, 4'h5, 32'h0000_0004);
    base <= 16'h0028;
    repeat (150) @(posedge clk);
    wb(1, 4'h4, 32'h0000_0000);
    wb(1, 4'h3, 32'h0000_0014);
    repeat (60) @(posedge clk);
    chk("pre stop dum", dum, 32'h0000_001f);
    chk("pre stop shed", shd, 32'h0000_001f);
    stp <= 1'b1;
    do @(posedge clk); while (sw_open !== 1'b1);
    chk("stop dum", dum, 0);
    chk("stop shed", shd, 0);
    on_ld <= 1'b0;
    repeat (10) @(posedge clk);
    $display("test stop done");
    stop_test();
  end
  // Watchdog
  initial begin
    repeat (4000) @(posedge clk);
    fails++;
    stop_test();
  end
endmodule
`default_nettype wire
